// ==== asc_map.svh ====
// register offsets, field positions, reset values and counts of the serial block
`ifndef ASC_MAP_SVH
`define ASC_MAP_SVH
`define ASC_SR_OFS     8'h50
`define ASC_DR_OFS     8'h51
`define ASC_BRR_OFS    8'h52
`define ASC_CR1_OFS    8'h53
`define ASC_CR2_OFS    8'h54
`define ASC_RXF_OFS    8'h55
`define ASC_TXF_OFS    8'h57
`define ASC_CTL_RST    8'h00
`define ASC_TXF_RST    1'b1
`define ASC_BRR_PS     7:6
`define ASC_BRR_TX     5:3
`define ASC_BRR_RX     2:0
`define ASC_CR1_R8     7
`define ASC_CR1_T8     6
`define ASC_CR1_M      4
`define ASC_CR1_WAKE   3
`define ASC_PR_SEL0    4'h1
`define ASC_PR_SEL1    4'h3
`define ASC_PR_SEL2    4'h4
`define ASC_PR_SEL3    4'hD
`define ASC_CONV_BASE  9'h002
`define ASC_OVS_LAST   4'hF
`define ASC_RX_MID     4'h7
`define ASC_LEN8       4'hA
`define ASC_LEN9       4'hB
`endif

// ==== asc_pkg.sv ====
// types shared by the serial control and baud block
package asc_pkg;
  typedef struct packed {
    logic [7:0] addr;   // register address
    logic [7:0] wdata;  // write data
    logic       wr;     // write strobe
    logic       rd;     // read strobe
  } asc_bus_t;
  typedef struct packed {
    logic tx_empty_irq_en;
    logic tx_done_irq_en;
    logic rx_irq_en;
    logic idle_irq_en;
    logic tx_enable;
    logic rx_enable;
    logic rx_mute;
    logic send_break_req;
  } asc_cr2_t;
  typedef enum logic [1:0] {TXK_DATA = 2'b00, TXK_PRE = 2'b01, TXK_BRK = 2'b10} asc_txk_t;
  typedef enum logic {TX_IDLE = 1'b0, TX_SHIFT = 1'b1} asc_txs_t;
  typedef enum logic {RX_HUNT = 1'b0, RX_BITS = 1'b1} asc_rxs_t;
endpackage : asc_pkg

// ==== asc_remote_node.sv ====
// remote serial node: decodes the block's transmit line and sends frames to its receive line
module asc_remote_node (
  input  wire logic        clock_i,    // shared cpu clock
  input  wire logic        tx_i,       // block transmit line
  input  wire logic [15:0] bit_cyc_i,  // bit time in clocks
  input  wire logic        nine_i,     // nine data bits per word
  output logic             rx_o,       // block receive line, idle high
  output logic [8:0]       word_o,     // last word decoded
  output logic [7:0]       cnt_o       // words decoded so far
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rx_o   = 1'b1;
    word_o = '0;
    cnt_o  = '0;
  end
  // decoder: start bit checked at its middle, then one sample per bit time
  // a break also decodes as a zero word; the bench ignores those
  always begin : decode
    logic [8:0] w;
    @(posedge clock_i);
    if (tx_i === 1'b0) begin
      w = '0;
      repeat (bit_cyc_i / 2) @(posedge clock_i);
      if (tx_i === 1'b0) begin
        for (int i = 0; i < 9; i++) begin
          if (i < 8 || nine_i) begin
            repeat (bit_cyc_i) @(posedge clock_i);
            w[i] = tx_i;  // lsb first, ninth bit last
          end
        end
        word_o <= w;
        cnt_o  <= cnt_o + 8'h01;
        repeat (bit_cyc_i) @(posedge clock_i);  // skip the stop bit
      end
    end
  end
  // sender: start 0, data lsb first, optional ninth bit, stop 1; line left high
  task automatic send_word(input logic [8:0] w);
    logic [10:0] f;
    f = nine_i ? {1'b1, w, 1'b0} : {2'b11, w[7:0], 1'b0};  // frame layout
    for (int i = 0; i < (nine_i ? 11 : 10); i++) begin
      @(posedge clock_i);
      rx_o <= f[i];
      repeat (bit_cyc_i - 16'h0001) @(posedge clock_i);
    end
  endtask : send_word
endmodule : asc_remote_node

// ==== asc_top.sv ====
// serial control, data and baud-rate register logic with its shifters
// Behaviour
// - word length bit picks eight or nine data
// - nine-bit mode stores received ninth bit
// - nine-bit mode sends held ninth bit
// - wake method: idle line or address mark
// - tx empty enable requests irq on empty
// - tx done enable requests irq on complete
// - rx enable requests irq on overrun/full
// - idle enable requests irq on idle flag
// - tx enable gives pin to serial function
// - tx enable off-on sends one preamble after
// - rx enable starts start-bit hunt
// - mute bit set by software, hardware clears
// - held break request sends breaks continuously
// - break request pulse appends one break
// - data write to tx buffer, read rx
// - prescale field gives 1, 3, 4, 13
// - tx divisor is two to field power
// - rx divisor is two to field power
// - nonzero tx fine divider replaces divisor
// - nonzero rx fine divider replaces divisor
// - rx rate is clock/16 over fine value
// - tx rate is clock/16 over fine value
// - conventional rate clock/32/prescale/divisor, independent
// - muted receiver sets no flags, no irqs
// - idle wake clears mute, no idle flag
// - address mark word wakes and is received
//
// Decided for this implementation: the strobed register port.
`include "asc_map.svh"
module asc_top import asc_pkg::*; (
  input  wire logic       clock_i,       // cpu clock, 100 MHz
  input  wire logic       nrst_i,        // asynchronous reset, active low
  input  wire asc_bus_t   bus_i,         // register request
  output logic [7:0]      rdata_o,       // read data, cycle after read strobe
  input  wire logic       rx_i,          // serial receive line
  output logic            tx_o,          // serial transmit line
  output logic            tx_pin_sel_o,  // high while pin belongs to serial function
  output logic            irq_o          // shared serial interrupt request
);

  // prescale factor lookup
  function automatic logic [3:0] pr_limit(input logic [1:0] sel);
    case (sel)
      2'b00:   pr_limit = `ASC_PR_SEL0;
      2'b01:   pr_limit = `ASC_PR_SEL1;
      2'b10:   pr_limit = `ASC_PR_SEL2;
      default: pr_limit = `ASC_PR_SEL3;
    endcase
  endfunction : pr_limit

  // oversample divide count; a nonzero fine value wins over the power of two
  function automatic logic [8:0] rate_limit(input logic [7:0] fine, input logic [2:0] rate);
    rate_limit = (fine != 8'h00) ? {1'b0, fine} : (`ASC_CONV_BASE << rate);
  endfunction : rate_limit

  // one step of a wrapping divider; >= keeps it safe when the limit shrinks
  function automatic logic [8:0] div_next(input logic [8:0] cnt, input logic [8:0] lim,
                                          input logic step);
    if (!step)
      div_next = cnt;
    else if (cnt >= lim - 9'h001)
      div_next = 9'h000;
    else
      div_next = cnt + 9'h001;
  endfunction : div_next

  // reset release synchroniser
  logic [1:0] rst_sync_r;                // two-stage release
  wire        rst_n = rst_sync_r[1];     // synchronised reset, active low
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i)
      rst_sync_r <= 2'b00;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end

  // address decode
  wire sel_sr  = bus_i.addr == `ASC_SR_OFS;
  wire sel_dr  = bus_i.addr == `ASC_DR_OFS;
  wire sel_brr = bus_i.addr == `ASC_BRR_OFS;
  wire sel_cr1 = bus_i.addr == `ASC_CR1_OFS;
  wire sel_cr2 = bus_i.addr == `ASC_CR2_OFS;
  wire sel_rxf = bus_i.addr == `ASC_RXF_OFS;
  wire sel_txf = bus_i.addr == `ASC_TXF_OFS;
  wire rd_sr   = bus_i.rd && sel_sr;
  wire rd_dr   = bus_i.rd && sel_dr;
  wire wr_dr   = bus_i.wr && sel_dr;

  // software registers
  logic [7:0] brr_r;       // baud_select
  logic [7:0] rxf_r;       // rx_fine_divider
  logic [7:0] txf_r;       // tx_fine_divider
  logic [7:0] tdr_r;       // tx_holding_buf
  logic [7:0] rdr_r;       // rx_holding_buf
  logic       t8_r;        // tx_ninth_bit
  logic       r8_r;        // rx_ninth_bit
  logic       m_r;         // nine-bit word length
  logic       wake_r;      // wake method, 1 = address mark
  asc_cr2_t   cr2_r;       // enable_control
  logic       mute_clr;    // hardware wake-up
  logic       rx_take;     // received word goes to software
  logic [10:0] rx_fr;      // complete received frame

  // control register writes; a software write to the mute bit beats a wake
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      brr_r  <= `ASC_CTL_RST;
      rxf_r  <= `ASC_CTL_RST;
      txf_r  <= `ASC_CTL_RST;
      tdr_r  <= `ASC_CTL_RST;
      cr2_r  <= asc_cr2_t'(`ASC_CTL_RST);
      t8_r   <= 1'b0;
      m_r    <= 1'b0;
      wake_r <= 1'b0;
    end else begin
      if (bus_i.wr && sel_brr) brr_r <= bus_i.wdata;
      if (bus_i.wr && sel_rxf) rxf_r <= bus_i.wdata;
      if (bus_i.wr && sel_txf) txf_r <= bus_i.wdata;
      if (wr_dr) tdr_r <= bus_i.wdata;
      if (bus_i.wr && sel_cr1) begin
        t8_r   <= bus_i.wdata[`ASC_CR1_T8];
        m_r    <= bus_i.wdata[`ASC_CR1_M];
        wake_r <= bus_i.wdata[`ASC_CR1_WAKE];
      end
      if (bus_i.wr && sel_cr2)
        cr2_r <= asc_cr2_t'(bus_i.wdata);
      else if (mute_clr)
        cr2_r.rx_mute <= 1'b0;
    end
  end

  // common prescaler: one tick per prescale factor of cpu clocks
  logic [3:0] pr_cnt_r;
  wire [3:0]  pr_lim  = pr_limit(brr_r[`ASC_BRR_PS]);
  wire        pr_tick = pr_cnt_r >= pr_lim - 4'h1;
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n)
      pr_cnt_r <= 4'h0;
    else
      pr_cnt_r <= pr_tick ? 4'h0 : pr_cnt_r + 4'h1;
  end

  // per-direction dividers make the 16x oversample tick; the bit is 16 of them,
  // so conventional = clk/(PR*2*div*16) and extended = clk/(16*fine)
  logic [8:0] tx_cnt_r;
  logic [8:0] rx_cnt_div_r;
  wire        tx_step   = (txf_r != 8'h00) || pr_tick;
  wire        rx_step   = (rxf_r != 8'h00) || pr_tick;
  wire [8:0]  tx_lim    = rate_limit(txf_r, brr_r[`ASC_BRR_TX]);
  wire [8:0]  rx_lim    = rate_limit(rxf_r, brr_r[`ASC_BRR_RX]);
  wire        tx_tick16 = tx_step && (tx_cnt_r >= tx_lim - 9'h001);
  wire        rx_tick16 = rx_step && (rx_cnt_div_r >= rx_lim - 9'h001);
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_cnt_r     <= 9'h000;
      rx_cnt_div_r <= 9'h000;
    end else begin
      tx_cnt_r     <= div_next(tx_cnt_r, tx_lim, tx_step);
      rx_cnt_div_r <= div_next(rx_cnt_div_r, rx_lim, rx_step);
    end
  end

  // transmitter state
  asc_txs_t    tx_st_r;     // idle or shifting
  asc_txk_t    tx_kind_r;   // what the current frame is
  logic [10:0] tx_sh_r;     // output shifter, lsb first
  logic [3:0]  tx_left_r;   // bits still to send
  logic [3:0]  tx_os_r;     // oversample phase
  logic        tx_buf_empty_r;      // tx_buf_empty
  logic        tc_r;        // tx_complete
  logic        sr_seen_r;   // status read armed a flag clear
  logic        pre_pend_r;  // preamble owed
  logic        brk_pend_r;  // single break owed
  logic        te_d_r;      // tx enable last cycle
  logic        sbk_d_r;     // break request last cycle

  wire [3:0]  frame_len = m_r ? `ASC_LEN9 : `ASC_LEN8;
  wire        tx_bit    = tx_tick16 && (tx_os_r == `ASC_OVS_LAST);
  wire        tx_last   = (tx_st_r == TX_SHIFT) && (tx_left_r == 4'h1);
  wire        tx_slot   = tx_bit && ((tx_st_r == TX_IDLE) || tx_last);
  wire        tx_end    = tx_bit && tx_last;
  // frames follow back to back; break outranks preamble outranks data
  wire go_brk = tx_slot && cr2_r.tx_enable
              && (cr2_r.send_break_req || brk_pend_r);
  wire go_pre = tx_slot && cr2_r.tx_enable && pre_pend_r && !go_brk;
  wire go_dat = tx_slot && cr2_r.tx_enable && !tx_buf_empty_r && !go_brk && !go_pre;
  wire [10:0] dat_frame = m_r ? {1'b1, t8_r, tdr_r, 1'b0}
                              : {2'b11, tdr_r, 1'b0};
  wire [10:0] new_frame = go_brk ? 11'h000 : (go_pre ? 11'h7FF : dat_frame);
  wire        tx_clr    = wr_dr && sr_seen_r;
  wire        te_rise   = cr2_r.tx_enable && !te_d_r;
  wire        sbk_rise  = cr2_r.send_break_req && !sbk_d_r;

  // shifter sequencing; a frame in flight always finishes
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_st_r   <= TX_IDLE;
      tx_kind_r <= TXK_DATA;
      tx_sh_r   <= 11'h7FF;
      tx_left_r <= 4'h0;
      tx_os_r   <= 4'h0;
    end else begin
      if (tx_tick16) tx_os_r <= tx_os_r + 4'h1;
      if (go_brk || go_pre || go_dat) begin
        tx_st_r   <= TX_SHIFT;
        tx_sh_r   <= new_frame;
        tx_left_r <= frame_len;
        tx_kind_r <= go_brk ? TXK_BRK : (go_pre ? TXK_PRE : TXK_DATA);
      end else if (tx_bit && (tx_st_r == TX_SHIFT)) begin
        if (tx_last) begin
          tx_st_r <= TX_IDLE;
        end else begin
          tx_sh_r   <= {1'b1, tx_sh_r[10:1]};
          tx_left_r <= tx_left_r - 4'h1;
        end
      end
    end
  end

  // transmit flags; hardware sets win over the software clear sequence
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_buf_empty_r     <= `ASC_TXF_RST;
      tc_r       <= `ASC_TXF_RST;
      sr_seen_r  <= 1'b0;
      pre_pend_r <= 1'b0;
      brk_pend_r <= 1'b0;
      te_d_r     <= 1'b0;
      sbk_d_r    <= 1'b0;
    end else begin
      tx_buf_empty_r     <= go_dat || (tx_buf_empty_r && !tx_clr);
      tc_r       <= tx_end || (tc_r && !tx_clr);
      sr_seen_r  <= rd_sr || (sr_seen_r && !(wr_dr || rd_dr));
      pre_pend_r <= te_rise || (pre_pend_r && !go_pre);
      brk_pend_r <= sbk_rise || (brk_pend_r && !go_brk);
      te_d_r     <= cr2_r.tx_enable;
      sbk_d_r    <= cr2_r.send_break_req;
    end
  end

  // receiver state
  asc_rxs_t    rx_st_r;     // hunting or sampling bits
  logic [3:0]  rx_os_r;     // oversample phase
  logic [3:0]  rx_cnt_r;    // bits sampled so far
  logic [3:0]  idle_cnt_r;  // whole high bit times seen
  logic [10:0] rx_sh_r;     // input shifter, fills from the top
  logic        rx_full_r;      // rx_full
  logic        idle_r;      // idle line flag
  logic        ovr_r;       // overrun flag
  logic        fe_r;        // framing error flag
  logic        idle_arm_r;  // idle may be flagged again

  wire rx_samp  = rx_tick16 && (rx_os_r == `ASC_OVS_LAST) && (rx_st_r == RX_BITS);
  wire rx_false = rx_samp && (rx_cnt_r == 4'h0) && rx_i;
  wire rx_done  = rx_samp && (rx_cnt_r == frame_len - 4'h1);
  assign rx_fr  = {rx_i, rx_sh_r[10:1]};
  // the word's top bit lands at frame bit 9 in both lengths
  wire [7:0] rx_byte  = m_r ? rx_fr[8:1] : rx_fr[9:2];
  wire wake_am  = rx_done && cr2_r.rx_mute && wake_r && rx_fr[9];
  assign rx_take = rx_done && (!cr2_r.rx_mute || wake_am);
  wire rx_load  = rx_take && !rx_full_r;
  wire hunt_bit = rx_tick16 && (rx_os_r == `ASC_OVS_LAST) && (rx_st_r == RX_HUNT);
  wire idle_evt = hunt_bit && rx_i && (idle_cnt_r == frame_len - 4'h1);
  wire wake_il  = idle_evt && cr2_r.rx_mute && !wake_r;
  wire idle_set = idle_evt && !cr2_r.rx_mute && idle_arm_r;
  wire rx_clr   = rd_dr && sr_seen_r;
  assign mute_clr = wake_am || wake_il;

  // start hunt, mid-bit sampling and idle counting; idle counts only while hunting
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_st_r    <= RX_HUNT;
      rx_os_r    <= 4'h0;
      rx_cnt_r   <= 4'h0;
      rx_sh_r    <= 11'h7FF;
      idle_cnt_r <= 4'h0;
    end else if (!cr2_r.rx_enable) begin
      rx_st_r    <= RX_HUNT;
      idle_cnt_r <= 4'h0;
    end else begin
      if (rx_tick16) rx_os_r <= rx_os_r + 4'h1;
      if (!rx_i)
        idle_cnt_r <= 4'h0;
      else if (hunt_bit && (idle_cnt_r < frame_len))
        idle_cnt_r <= idle_cnt_r + 4'h1;
      case (rx_st_r)
        RX_HUNT: begin
          if (rx_tick16 && !rx_i) begin
            rx_st_r  <= RX_BITS;
            rx_os_r  <= `ASC_RX_MID;
            rx_cnt_r <= 4'h0;
          end
        end
        default: begin
          if (rx_samp) begin
            rx_sh_r  <= rx_fr;
            rx_cnt_r <= rx_cnt_r + 4'h1;
            if (rx_false || rx_done) rx_st_r <= RX_HUNT;
          end
        end
      endcase
    end
  end

  // receive buffer and flags; holding buffer is kept on overrun
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      rdr_r      <= 8'h00;
      r8_r       <= 1'b0;
      rx_full_r     <= 1'b0;
      idle_r     <= 1'b0;
      ovr_r      <= 1'b0;
      fe_r       <= 1'b0;
      idle_arm_r <= 1'b1;
    end else begin
      if (rx_load) rdr_r <= rx_byte;
      if (rx_load && m_r) r8_r <= rx_fr[9];
      rx_full_r     <= rx_load || (rx_full_r && !rx_clr);
      ovr_r      <= (rx_take && rx_full_r) || (ovr_r && !rx_clr);
      fe_r       <= (rx_load && !rx_fr[10]) || (fe_r && !rx_clr);
      idle_r     <= idle_set || (idle_r && !rx_clr);
      idle_arm_r <= rx_load || (idle_arm_r && !idle_set);
    end
  end

  // read data selection
  logic [7:0] rd_val;
  always_comb begin
    if (sel_sr)
      rd_val = {tx_buf_empty_r, tc_r, rx_full_r, idle_r, ovr_r, 1'b0, fe_r, 1'b0};
    else if (sel_dr)
      rd_val = rdr_r;
    else if (sel_brr)
      rd_val = brr_r;
    else if (sel_cr1)
      rd_val = {r8_r, t8_r, 1'b0, m_r, wake_r, 3'b000};
    else if (sel_cr2)
      rd_val = cr2_r;
    else if (sel_rxf)
      rd_val = rxf_r;
    else if (sel_txf)
      rd_val = txf_r;
    else
      rd_val = 8'h00;
  end

  // registered outputs; muted receiver raises no receive request
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_o      <= 8'h00;
      tx_o         <= 1'b1;
      tx_pin_sel_o <= 1'b0;
      irq_o        <= 1'b0;
    end else begin
      rdata_o      <= bus_i.rd ? rd_val : 8'h00;
      tx_o         <= (tx_st_r == TX_SHIFT) ? tx_sh_r[0] : 1'b1;
      tx_pin_sel_o <= cr2_r.tx_enable || (tx_st_r == TX_SHIFT);
      irq_o        <= (cr2_r.tx_empty_irq_en && tx_buf_empty_r)
                   || (cr2_r.tx_done_irq_en && tc_r)
                   || (cr2_r.rx_irq_en && !cr2_r.rx_mute && (ovr_r || rx_full_r))
                   || (cr2_r.idle_irq_en && !cr2_r.rx_mute && idle_r);
    end
  end

  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n);

  sequence te_reopen;
    !cr2_r.tx_enable ##1 cr2_r.tx_enable;
  endsequence
  sequence sbk_drop;
    cr2_r.send_break_req ##1 !cr2_r.send_break_req;
  endsequence

  a_irq_tx_empty: assert property (cr2_r.tx_empty_irq_en && tx_buf_empty_r |=> irq_o)
    else $error("empty flag did not raise irq");
  a_irq_tx_done: assert property (cr2_r.tx_done_irq_en && tc_r |=> irq_o)
    else $error("complete flag did not raise irq");
  a_irq_rx_data: assert property (cr2_r.rx_irq_en && !cr2_r.rx_mute
      && (rx_full_r || ovr_r) |=> irq_o)
    else $error("receive flag did not raise irq");
  a_irq_idle_line: assert property (cr2_r.idle_irq_en && !cr2_r.rx_mute && idle_r |=> irq_o)
    else $error("idle flag did not raise irq");
  a_pin_owner: assert property (cr2_r.tx_enable |=> tx_pin_sel_o)
    else $error("pin not handed to serial function");
  a_preamble_owed: assert property (te_reopen |=> pre_pend_r || tx_kind_r == TXK_PRE)
    else $error("preamble not scheduled after enable pulse");
  a_break_owed: assert property (sbk_drop |-> brk_pend_r || tx_kind_r == TXK_BRK)
    else $error("single break not scheduled");
  a_break_low: assert property (tx_st_r == TX_SHIFT && tx_kind_r == TXK_BRK
      |=> !tx_o)
    else $error("break frame drove line high");
  a_mute_quiet: assert property ($rose(idle_r) |-> !$past(cr2_r.rx_mute))
    else $error("idle flagged while muted");
  a_idle_wake: assert property (wake_il |=> !cr2_r.rx_mute && !idle_r)
    else $error("idle wake set idle flag or kept mute");
  a_addr_wake: assert property (wake_am && !rx_full_r |=> rx_full_r && !cr2_r.rx_mute)
    else $error("address mark word not received");

endmodule : asc_top

// ==== asc_top_bench.sv ====
// self-checking bench of the serial control and baud block
`include "asc_map.svh"
module asc_top_bench import asc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0]  baud;    // baud_select value
    logic [7:0]  fine;    // tx_fine_divider value
    logic [15:0] bitlen;  // expected start bit in clocks
  } asc_row_t;
  logic        clock_i    = 1'b0;      // cpu clock, 100 MHz
  logic        nrst_i     = 1'b0;      // reset, active low
  asc_bus_t    bus_i      = '0;        // register request
  logic [7:0]  rdata_o;                // read data
  logic        rx_i;                   // line from the remote node
  logic        tx_o;                   // line to the remote node
  logic        tx_pin_sel_o;           // pin ownership
  logic        irq_o;                  // interrupt request
  logic [15:0] node_bit   = 16'h0010;  // remote bit time: fine divider 1 gives 16 clocks
  logic        node_nine  = 1'b0;      // remote word length
  logic [8:0]  node_word;              // last word the remote saw
  logic [7:0]  node_cnt;               // words the remote saw
  int          errors     = 0;         // mismatches
  int          num_checks = 0;         // comparisons
  int          cycles     = 0;         // clock cycles since start
  int          run;                    // length of a low stretch
  logic [7:0]  cnt0;                   // word count before a send
  // rate settings; the rx field differs per row to show it does not touch tx
  asc_row_t    rows [5] = '{'{8'h07, 8'h00, 16'h0020}, '{8'h4A, 8'h00, 16'h00C0},
                            '{8'h90, 8'h00, 16'h0200}, '{8'hC5, 8'h00, 16'h01A0},
                            '{8'hD7, 8'h05, 16'h0050}};
  logic [7:0]  zaddr [6] = '{8'h52, 8'h53, 8'h54, 8'h55, 8'h57, 8'h56};  // read zero after reset
  asc_top u_dut (
    .clock_i      (clock_i),
    .nrst_i       (nrst_i),
    .bus_i        (bus_i),
    .rdata_o      (rdata_o),
    .rx_i         (rx_i),
    .tx_o         (tx_o),
    .tx_pin_sel_o (tx_pin_sel_o),
    .irq_o        (irq_o)
  );
  asc_remote_node u_node (
    .clock_i   (clock_i),
    .tx_i      (tx_o),
    .bit_cyc_i (node_bit),
    .nine_i    (node_nine),
    .rx_o      (rx_i),
    .word_o    (node_word),
    .cnt_o     (node_cnt)
  );
  always #5 clock_i = ~clock_i;
  // hang guard: the whole run needs about 30000 cycles
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 60000) begin
      errors++;
      end_sim();
    end
  end
  task automatic check(input string what, input logic [15:0] e, input logic [15:0] got);
    num_checks++;
    if (got !== e) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, e, got);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    bus_i <= '{a, d, 1'b1, 1'b0};
    @(posedge clock_i);
    bus_i <= '0;
  endtask : wr
  // read data stand only in the cycle after the strobe edge
  task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e,
                     input string what);
    @(posedge clock_i);
    bus_i <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clock_i);
    bus_i <= '0;
    #1;
    check(what, {8'h00, e}, {8'h00, rdata_o & m});
  endtask : rdc
  // waits for the line to fall, then counts clocks until it rises
  task automatic low_run(output int n);
    int k;
    n = 0;
    k = 0;
    while (tx_o !== 1'b0 && k < 20000) begin
      @(posedge clock_i);
      k++;
    end
    while (tx_o === 1'b0 && n < 20000) begin
      @(posedge clock_i);
      n++;
    end
  endtask : low_run
  // a running frame always finishes, so the pin is only free afterwards
  task automatic wait_free();
    int k;
    k = 0;
    while (tx_pin_sel_o !== 1'b0 && k < 20000) begin
      @(posedge clock_i);
      k++;
    end
  endtask : wait_free
  task automatic end_sim();
    $display("checks %0d, errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim
  initial begin
    repeat (3) @(posedge clock_i);
    check("tx line in reset", 16'h0001, 16'(tx_o));
    check("irq in reset", 16'h0000, 16'(irq_o));
    check("pin in reset", 16'h0000, 16'(tx_pin_sel_o));
    repeat (2) @(posedge clock_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    rdc(`ASC_SR_OFS, 8'hFF, 8'hC0, "status reset");
    foreach (zaddr[i]) rdc(zaddr[i], 8'hFF, 8'h00, "register reset");
    wr(`ASC_CR1_OFS, 8'hD8);
    rdc(`ASC_CR1_OFS, 8'hFF, 8'h58, "frame_control");
    wr(8'h56, 8'h5A);
    rdc(8'h56, 8'hFF, 8'h00, "unmapped");
    wr(`ASC_SR_OFS, 8'h00);
    rdc(`ASC_SR_OFS, 8'hFF, 8'hC0, "status write");
    wr(`ASC_CR1_OFS, 8'h00);
    // ordinary cases: start bit of an all-ones word at each rate setting
    foreach (rows[i]) begin
      wr(`ASC_CR2_OFS, 8'h00);
      wait_free();
      wr(`ASC_BRR_OFS, rows[i].baud);
      wr(`ASC_TXF_OFS, rows[i].fine);
      wr(`ASC_CR2_OFS, 8'h08);
      // the status read arms the clear, so the data write releases the empty flag
      rdc(`ASC_SR_OFS, 8'hC0, 8'hC0, "tx flags before load");
      wr(`ASC_DR_OFS, 8'hFF);
      low_run(run);
      check("start bit clocks", rows[i].bitlen, 16'(run));
    end
    // nine-bit word with the held ninth bit, behind the preamble
    wr(`ASC_CR2_OFS, 8'h00);
    wait_free();
    wr(`ASC_TXF_OFS, 8'h01);
    wr(`ASC_CR1_OFS, 8'h50);
    node_nine = 1'b1;
    wr(`ASC_CR2_OFS, 8'h08);
    rdc(`ASC_SR_OFS, 8'hC0, 8'hC0, "tx flags before nine-bit load");
    cnt0 = node_cnt;
    wr(`ASC_DR_OFS, 8'hA5);
    for (int k = 0; k < 2000 && node_cnt === cnt0; k++) @(posedge clock_i);
    check("tx word", 16'h01A5, {7'h00, node_word});
    check("pin serial", 16'h0001, 16'(tx_pin_sel_o));
    wr(`ASC_CR2_OFS, 8'h00);
    wait_free();
    check("pin released", 16'h0000, 16'(tx_pin_sel_o));
    // held break keeps the line low; a pulse of the request gives exactly one break
    node_nine = 1'b0;
    wr(`ASC_CR1_OFS, 8'h00);
    wr(`ASC_CR2_OFS, 8'h09);
    repeat (400) @(posedge clock_i);
    check("held break", 16'h0000, 16'(tx_o));
    wr(`ASC_CR2_OFS, 8'h08);
    low_run(run);
    repeat (50) @(posedge clock_i);
    wr(`ASC_CR2_OFS, 8'h09);
    wr(`ASC_CR2_OFS, 8'h08);
    low_run(run);
    check("break clocks", 16'h00A0, 16'(run));
    repeat (300) @(posedge clock_i);
    check("single break", 16'h0001, 16'(tx_o));
    // transmit interrupts follow their flags
    wr(`ASC_CR2_OFS, 8'h80);
    repeat (2) @(posedge clock_i);
    check("irq empty", 16'h0001, 16'(irq_o));
    wr(`ASC_CR2_OFS, 8'h40);
    repeat (2) @(posedge clock_i);
    check("irq complete", 16'h0001, 16'(irq_o));
    rdc(`ASC_SR_OFS, 8'hC0, 8'hC0, "tx flags");
    wr(`ASC_DR_OFS, 8'h00);
    repeat (2) @(posedge clock_i);
    check("irq complete cleared", 16'h0000, 16'(irq_o));
    wr(`ASC_CR2_OFS, 8'h80);
    repeat (2) @(posedge clock_i);
    check("irq empty cleared", 16'h0000, 16'(irq_o));
    // muted receiver with address mark wake-up
    wr(`ASC_RXF_OFS, 8'h01);
    wr(`ASC_CR1_OFS, 8'h08);
    wr(`ASC_CR2_OFS, 8'h26);
    u_node.send_word(9'h012);
    repeat (40) @(posedge clock_i);
    rdc(`ASC_SR_OFS, 8'h20, 8'h00, "full while muted");
    check("irq while muted", 16'h0000, 16'(irq_o));
    u_node.send_word(9'h092);
    repeat (40) @(posedge clock_i);
    rdc(`ASC_CR2_OFS, 8'hFF, 8'h24, "mute after mark");
    check("irq rx full", 16'h0001, 16'(irq_o));
    rdc(`ASC_SR_OFS, 8'h20, 8'h20, "full after mark");
    rdc(`ASC_DR_OFS, 8'hFF, 8'h92, "rx data");
    rdc(`ASC_SR_OFS, 8'h20, 8'h00, "full cleared");
    check("irq rx cleared", 16'h0000, 16'(irq_o));
    // nine-bit reception stores the ninth bit
    wr(`ASC_CR1_OFS, 8'h10);
    node_nine = 1'b1;
    u_node.send_word(9'h155);
    repeat (40) @(posedge clock_i);
    rdc(`ASC_CR1_OFS, 8'h80, 8'h80, "rx ninth bit");
    rdc(`ASC_DR_OFS, 8'hFF, 8'h55, "rx nine-bit data");
    // idle line wake-up clears mute without flagging idle; a later idle is flagged
    node_nine = 1'b0;
    wr(`ASC_CR1_OFS, 8'h00);
    wr(`ASC_CR2_OFS, 8'h06);
    repeat (400) @(posedge clock_i);
    rdc(`ASC_CR2_OFS, 8'hFF, 8'h04, "mute after idle");
    rdc(`ASC_SR_OFS, 8'h10, 8'h00, "idle on wake");
    u_node.send_word(9'h033);
    wr(`ASC_CR2_OFS, 8'h14);
    repeat (300) @(posedge clock_i);
    check("irq idle", 16'h0001, 16'(irq_o));
    rdc(`ASC_SR_OFS, 8'h30, 8'h30, "idle after word");
    // a second word while full overruns and the held word survives
    u_node.send_word(9'h044);
    rdc(`ASC_SR_OFS, 8'h28, 8'h28, "overrun");
    rdc(`ASC_DR_OFS, 8'hFF, 8'h33, "kept on overrun");
    end_sim();
  end
endmodule : asc_top_bench
